// file: src/fdp_cfg.svh
/*
  Constants of the flyback dimming and protection block: timing figures,
  thresholds and reset values.
  Assumes a 100 MHz core clock and is included by the top module.
*/
`ifndef FDP_CFG_SVH
`define FDP_CFG_SVH
`define FDP_CLK_KHZ      100000
`define FDP_CLK_MHZ      100
`define FDP_RESTART_MS   400
`define FDP_START_MAX_MS 100
`define FDP_DIM_SW_HZ    1000
`define FDP_HSP_US       9823
`define FDP_OCP_BLANK_NS 240
`define FDP_OCP1_MID     8'h36
`define FDP_OCP1_HIGH    8'h48
`define FDP_OCP2_LO_MV   12'h320
`define FDP_OCP2_MID_MV  12'h4b0
`define FDP_OCP2_HI_MV   12'h640
`define FDP_PU_MIN       8'h09
`define FDP_PU_MAX       8'h78
`define FDP_UV_SHIFT     1
`define FDP_DUTY_FULL    8'hff
`define FDP_SP_RST       16'h0000
`define FDP_TON_RST      16'h0000
`endif

// file: src/fdp_pkg.sv
/*
  Types of the flyback dimming and protection block.
  Assumes nothing of its surroundings.
*/
package fdp_pkg;
  typedef enum logic [2:0] {
    ST_INIT  = 3'b000,
    ST_START = 3'b001,
    ST_REG   = 3'b010,
    ST_SLEEP = 3'b011,
    ST_MEAS  = 3'b100,
    ST_FAULT = 3'b101
  } fdp_state_e;
  typedef enum logic [1:0] {
    DV_IDLE = 2'b00,
    DV_DUTY = 2'b01,
    DV_NORM = 2'b10
  } fdp_div_e;
  typedef enum logic [1:0] {
    FC_NONE     = 2'b00,
    FC_OCP      = 2'b01,
    FC_UV       = 2'b10,
    FC_START_UV = 2'b11
  } fdp_cause_e;
  typedef struct packed {
    logic       inv;
    logic       quad;
    logic       with_off;
    logic [7:0] hyst;
    logic [7:0] dmin;
    logic [7:0] dmax;
    logic [7:0] doff;
    logic [7:0] don;
  } fdp_dim_cfg_s;
  typedef struct packed {
    logic [15:0] vin;
    logic [15:0] vout;
    logic [15:0] iout;
  } fdp_est_s;
endpackage

// file: src/fdp_top.sv
/*
  Dimming, on-time modulation and protection control of a flyback LED
  controller. Expects estimated voltages and current from the sensing path,
  a valley pulse from the zero crossing pin and a synchronous dimming input.
*/
`include "fdp_cfg.svh"
module fdp_top
  import fdp_pkg::*;
#(
  parameter int unsigned RESTART_CYC   = `FDP_RESTART_MS * `FDP_CLK_KHZ,
  parameter int unsigned START_MAX_CYC = `FDP_START_MAX_MS * `FDP_CLK_KHZ,
  parameter int unsigned DIM_SW_CYC    = (`FDP_CLK_KHZ * 1000) / `FDP_DIM_SW_HZ,
  parameter int unsigned HSP_CYC       = `FDP_HSP_US * `FDP_CLK_MHZ,
  parameter int unsigned OCP_BLANK_CYC = (`FDP_OCP_BLANK_NS * `FDP_CLK_MHZ + 999) / 1000
)(
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  // dimming
  input  wire logic         dim_pwm_i,
  input  wire fdp_dim_cfg_s dim_cfg_i,
  input  wire logic [15:0]  iout_min_i,
  input  wire logic [15:0]  iout_full_i,
  input  wire logic         plim_en_i,
  input  wire logic [31:0]  pout_set_i,
  input  wire logic [7:0]   pullup_code_i,
  // power stage
  input  wire fdp_est_s     est_i,
  input  wire logic         qr1_mode_i,
  input  wire logic [7:0]   input_cap_comp_gain_i,
  input  wire logic [15:0]  ton_base_i,
  input  wire logic         valley_i,
  input  wire logic         line_sync_i,
  input  wire logic [23:0]  line_hsp_cyc_i,
  // protections
  input  wire logic [11:0]  cs_mv_i,
  input  wire logic [7:0]   first_overcurrent_level_i,
  input  wire logic [15:0]  vout_dim_min_i,
  input  wire logic [15:0]  vout_start_i,
  input  wire logic [23:0]  undervoltage_blanking_i,
  // outputs
  output logic              gate_drive_o,
  output logic              sleep_o,
  output logic              light_on_o,
  output logic              fault_o,
  output fdp_cause_e        fault_cause_o,
  output logic [15:0]       iout_set_o,
  output logic [7:0]        duty_o,
  output logic [15:0]       ton_o,
  output logic              enhanced_power_factor_o,
  output logic              pullup_en_o,
  output logic [11:0]       second_overcurrent_level_o
);

  if (RESTART_CYC < 1 || START_MAX_CYC < 1 || DIM_SW_CYC < 2 || HSP_CYC < 256 ||
      HSP_CYC > 24'hffffff || OCP_BLANK_CYC < 1 || OCP_BLANK_CYC > 16'hffff)
  begin : g_chk
    $error("fdp_top: timing parameter out of range");
  end

  // ***********************************************************
  // dimming input period and high time
  // ***********************************************************
  logic        pwm_p;
  logic        pwm_q;
  logic        seen_q;
  logic        prim_q;
  logic        rise;
  logic [19:0] hi_cnt_q;
  logic [19:0] per_cnt_q;

  assign pwm_p = dim_pwm_i ^ dim_cfg_i.inv;
  // no edge until the pin level has been sampled once after reset
  assign rise  = pwm_p & ~pwm_q & prim_q;

  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      pwm_q     <= 1'b0;
      prim_q    <= 1'b0;
      seen_q    <= 1'b0;
      hi_cnt_q  <= 20'h00000;
      per_cnt_q <= 20'h00000;
    end
    else
    begin
      pwm_q  <= pwm_p;
      prim_q <= 1'b1;
      if (rise)
      begin
        seen_q    <= 1'b1;
        hi_cnt_q  <= 20'h00001;
        per_cnt_q <= 20'h00001;
      end
      else
      begin
        if (per_cnt_q != 20'hfffff)
          per_cnt_q <= per_cnt_q + 20'h00001;
        if (pwm_p && hi_cnt_q != 20'hfffff)
          hi_cnt_q <= hi_cnt_q + 20'h00001;
      end
    end

  // ***********************************************************
  // serial divider: duty, then normalised duty
  // ***********************************************************
  fdp_div_e    dv_q;
  logic [20:0] rem_q;
  logic [20:0] rem2;
  logic [19:0] den_q;
  logic [7:0]  quo_q;
  logic [2:0]  cnt_q;
  logic        div_bit;
  logic        div_done;
  logic        duty_done;
  logic [7:0]  q_fin;
  logic [7:0]  duty_q;
  logic [7:0]  raw_q;
  logic [7:0]  duty_d;
  logic [7:0]  hdiff;
  logic [7:0]  nnum;
  logic        meas_q;

  assign rem2      = {rem_q[19:0], 1'b0};
  assign div_bit   = rem2 >= {1'b0, den_q};
  assign div_done  = (dv_q != DV_IDLE) && (cnt_q == 3'h7);
  assign duty_done = div_done && (dv_q == DV_DUTY);
  assign q_fin     = {quo_q[6:0], div_bit};
  assign hdiff     = (q_fin > duty_q) ? q_fin - duty_q : duty_q - q_fin;
  assign duty_d    = (hdiff > dim_cfg_i.hyst) ? q_fin : duty_q;
  assign nnum      = (duty_d > dim_cfg_i.dmin) ? duty_d - dim_cfg_i.dmin : 8'h00;

  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      dv_q  <= DV_IDLE;
      rem_q <= 21'h000000;
      den_q <= 20'h00000;
      quo_q <= 8'h00;
      cnt_q <= 3'h0;
    end
    else if (dv_q == DV_IDLE)
    begin
      if (rise && seen_q)
      begin
        rem_q <= {1'b0, hi_cnt_q};
        den_q <= per_cnt_q;
        quo_q <= 8'h00;
        cnt_q <= 3'h0;
        dv_q  <= DV_DUTY;
      end
    end
    else
    begin
      rem_q <= div_bit ? rem2 - {1'b0, den_q} : rem2;
      quo_q <= q_fin;
      cnt_q <= cnt_q + 3'h1;
      if (duty_done)
      begin
        rem_q <= {13'h0000, nnum};
        den_q <= {12'h000, dim_cfg_i.dmax - dim_cfg_i.dmin};
        quo_q <= 8'h00;
        dv_q  <= DV_NORM;
      end
      else if (div_done)
        dv_q <= DV_IDLE;
    end

  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      duty_q <= 8'h00;
      raw_q  <= 8'h00;
      meas_q <= 1'b0;
    end
    else
    begin
      meas_q <= duty_done;
      if (duty_done)
      begin
        raw_q  <= q_fin;
        duty_q <= duty_d;
      end
    end

  // ***********************************************************
  // dimming curve and power limit
  // ***********************************************************
  logic [7:0]  x_q;
  logic [15:0] xsq;
  logic [7:0]  xe;
  logic [15:0] span;
  logic [23:0] sprod;
  logic [15:0] curve;
  logic [31:0] pprod;
  logic        over;
  logic [15:0] sp_q;
  logic        ph_tick;

  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
      x_q <= 8'h00;
    else if (div_done && dv_q == DV_NORM)
    begin
      if (duty_q <= dim_cfg_i.dmin)
        x_q <= 8'h00;
      else if (duty_q >= dim_cfg_i.dmax)
        x_q <= `FDP_DUTY_FULL;
      else
        x_q <= q_fin;
    end

  assign xsq   = x_q * x_q;
  assign xe    = dim_cfg_i.quad ? xsq[15:8] : x_q;
  assign span  = (iout_full_i > iout_min_i) ? iout_full_i - iout_min_i : 16'h0000;
  assign sprod = span * xe;
  assign pprod = est_i.vout * est_i.iout;
  assign over  = plim_en_i && (pprod > pout_set_i);

  always_comb
  begin
    curve = iout_min_i + sprod[23:8];
    if (x_q == `FDP_DUTY_FULL)
      curve = iout_full_i;
    if (!dim_cfg_i.with_off && (raw_q < dim_cfg_i.doff || raw_q < dim_cfg_i.dmin))
      curve = iout_min_i;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
      sp_q <= `FDP_SP_RST;
    else if (over)
    begin
      if (curve < sp_q)
        sp_q <= curve;
      else if (ph_tick && sp_q > iout_min_i)
        sp_q <= sp_q - 16'h0001;
    end
    else
      sp_q <= curve;

  // ***********************************************************
  // half sine period phase
  // ***********************************************************
  logic [23:0] hsp_sel;
  logic [15:0] step;
  logic [15:0] ph_cnt_q;
  logic [7:0]  ph_q;

  assign hsp_sel = line_sync_i ? line_hsp_cyc_i : 24'(HSP_CYC);
  assign step    = (hsp_sel[23:8] == 16'h0000) ? 16'h0001 : hsp_sel[23:8];
  assign ph_tick = ph_cnt_q >= step - 16'h0001;

  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      ph_cnt_q <= 16'h0000;
      ph_q     <= 8'h00;
    end
    else if (ph_tick)
    begin
      ph_cnt_q <= 16'h0000;
      ph_q     <= ph_q + 8'h01;
    end
    else
      ph_cnt_q <= ph_cnt_q + 16'h0001;

  // ***********************************************************
  // on-time modulation
  // ***********************************************************
  logic        enh_pf;
  logic [16:0] vsum;
  logic [16:0] kd;
  logic [7:0]  k8;
  logic [23:0] corr;
  logic [16:0] tsum;

  assign enh_pf = (input_cap_comp_gain_i != 8'h00) && qr1_mode_i;
  assign vsum = {1'b0, est_i.vout} + {1'b0, est_i.iout};
  assign kd   = (vsum > {1'b0, est_i.vin}) ? vsum - {1'b0, est_i.vin} : 17'h00000;
  assign k8   = kd[16] ? 8'hff : kd[15:8];
  assign corr = input_cap_comp_gain_i * ph_q * k8;
  assign tsum = {1'b0, ton_base_i} + {1'b0, corr[23:8]};

  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      ton_o                   <= `FDP_TON_RST;
      enhanced_power_factor_o <= 1'b0;
    end
    else
    begin
      enhanced_power_factor_o <= enh_pf;
      if (enh_pf)
        ton_o <= tsum[16] ? 16'hffff : tsum[15:0];
      else
        ton_o <= ton_base_i;
    end

  // ***********************************************************
  // protections
  // ***********************************************************
  fdp_state_e  state_q;
  logic [15:0] ocp_cnt_q;
  logic [23:0] uv_cnt_q;
  logic        cs_hi;
  logic        ocp_trip;
  logic        uv_low;
  logic        uv_trip;

  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
      second_overcurrent_level_o <= `FDP_OCP2_LO_MV;
    else if (first_overcurrent_level_i <= `FDP_OCP1_MID)
      second_overcurrent_level_o <= `FDP_OCP2_LO_MV;
    else if (first_overcurrent_level_i <= `FDP_OCP1_HIGH)
      second_overcurrent_level_o <= `FDP_OCP2_MID_MV;
    else
      second_overcurrent_level_o <= `FDP_OCP2_HI_MV;

  assign cs_hi    = gate_drive_o && (cs_mv_i > second_overcurrent_level_o);
  assign ocp_trip = cs_hi && (ocp_cnt_q >= 16'(OCP_BLANK_CYC));
  assign uv_low   = (state_q == ST_REG) &&
                    (est_i.vout < (vout_dim_min_i >> `FDP_UV_SHIFT));
  assign uv_trip  = uv_low && (uv_cnt_q >= undervoltage_blanking_i);

  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      ocp_cnt_q <= 16'h0000;
      uv_cnt_q  <= 24'h000000;
    end
    else
    begin
      ocp_cnt_q <= (cs_hi && !ocp_trip) ? ocp_cnt_q + 16'h0001 : 16'h0000;
      uv_cnt_q  <= (uv_low && !uv_trip) ? uv_cnt_q + 24'h000001 : 24'h000000;
    end

  // ***********************************************************
  // operating state
  // ***********************************************************
  fdp_state_e  st_d;
  logic [31:0] tmr_q;
  logic        charged;

  assign charged = est_i.vout >= vout_start_i;

  always_comb
  begin
    st_d = state_q;
    case (state_q)
      ST_INIT:
        if (meas_q)
          st_d = (dim_cfg_i.with_off && raw_q <= dim_cfg_i.doff) ? ST_SLEEP : ST_START;
      ST_START:
        if (ocp_trip)
          st_d = ST_FAULT;
        else if (charged)
          st_d = ST_REG;
        else if (tmr_q >= START_MAX_CYC - 1)
          st_d = ST_FAULT;
      ST_REG:
        if (ocp_trip || uv_trip)
          st_d = ST_FAULT;
        else if (meas_q && dim_cfg_i.with_off && raw_q < dim_cfg_i.doff)
          st_d = ST_SLEEP;
      ST_SLEEP:
        if (tmr_q >= RESTART_CYC - 1)
          st_d = ST_MEAS;
      ST_MEAS:
        if (ocp_trip)
          st_d = ST_FAULT;
        else if (meas_q && charged)
          st_d = (raw_q > dim_cfg_i.don) ? ST_REG : ST_SLEEP;
      ST_FAULT:
        if (tmr_q >= RESTART_CYC - 1)
          st_d = ST_START;
      default:
        st_d = ST_INIT;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      state_q       <= ST_INIT;
      tmr_q         <= 32'h00000000;
      sleep_o       <= 1'b0;
      light_on_o    <= 1'b0;
      fault_o       <= 1'b0;
      fault_cause_o <= FC_NONE;
    end
    else
    begin
      state_q    <= st_d;
      tmr_q      <= (st_d != state_q) ? 32'h00000000 : tmr_q + 32'h00000001;
      sleep_o    <= st_d == ST_SLEEP;
      light_on_o <= st_d == ST_REG || st_d == ST_START;
      fault_o    <= st_d == ST_FAULT;
      if (st_d == ST_FAULT && state_q != ST_FAULT)
        fault_cause_o <= ocp_trip ? FC_OCP : (uv_trip ? FC_UV : FC_START_UV);
    end

  // ***********************************************************
  // gate drive
  // ***********************************************************
  logic [31:0] sw_cnt_q;
  logic        sw_tick;
  logic [15:0] on_cnt_q;
  logic        gate_start;
  logic        gate_stop;

  assign sw_tick    = sw_cnt_q >= DIM_SW_CYC - 1;
  assign gate_start = ((state_q == ST_START || state_q == ST_REG) && valley_i) ||
                      (state_q == ST_MEAS && sw_tick && !charged);
  assign gate_stop  = (on_cnt_q >= ton_o) || ocp_trip ||
                      !(st_d == ST_START || st_d == ST_REG || st_d == ST_MEAS);

  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
      sw_cnt_q <= 32'h00000000;
    else
      sw_cnt_q <= (sw_tick || state_q != ST_MEAS) ? 32'h00000000 : sw_cnt_q + 32'h00000001;

  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      gate_drive_o <= 1'b0;
      on_cnt_q     <= 16'h0000;
    end
    else if (gate_drive_o)
    begin
      on_cnt_q <= on_cnt_q + 16'h0001;
      if (gate_stop)
      begin
        gate_drive_o <= 1'b0;
        on_cnt_q     <= 16'h0000;
      end
    end
    else if (gate_start && !gate_stop)
    begin
      gate_drive_o <= 1'b1;
      on_cnt_q     <= 16'h0001;
    end

  // ***********************************************************
  // status outputs
  // ***********************************************************
  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      iout_set_o  <= `FDP_SP_RST;
      duty_o      <= 8'h00;
      pullup_en_o <= 1'b0;
    end
    else
    begin
      iout_set_o  <= sp_q;
      duty_o      <= duty_q;
      pullup_en_o <= pullup_code_i >= `FDP_PU_MIN && pullup_code_i <= `FDP_PU_MAX;
    end

endmodule // fdp_top

// file: verif/fdp_pwm_src.sv
/*
  Dimming source model: a fixed-period PWM on the dimming line.
  Assumes the bench clock; the period is scaled down to keep runs short.
*/
module fdp_pwm_src
(
  // clock
  input  wire logic        clk_i,
  // waveform
  input  wire logic [15:0] period_i,
  input  wire logic [15:0] high_i,
  // dimming line
  output logic             pwm_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_q  = '0;
  logic [15:0] high_q = '0;
  initial pwm_o = 1'b0;
  // high time is taken at a period start only, so no period is torn
  always @(negedge clk_i)
  begin
    cnt_q <= (cnt_q + 16'h0001 >= period_i) ? 16'h0000 : cnt_q + 16'h0001;
    if (cnt_q == 16'h0000)
      high_q <= high_i;
    pwm_o <= (cnt_q < high_q);
  end
endmodule // fdp_pwm_src

// file: verif/fdp_top_sva.sv
/*
  Checker of the flyback dimming and protection block.
  Assumes it is bound to fdp_top and sees its ports only.
*/
module fdp_top_sva
  import fdp_pkg::*;
#(
  parameter int unsigned RESTART_CYC   = 200,
  parameter int unsigned OCP_BLANK_CYC = 24
)(
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  // watched inputs
  input wire logic [11:0] cs_mv_i,
  input wire logic [7:0]  first_overcurrent_level_i,
  input wire logic [7:0]  pullup_code_i,
  input wire logic [7:0]  input_cap_comp_gain_i,
  // watched outputs
  input wire logic        gate_drive_o,
  input wire logic        sleep_o,
  input wire logic        light_on_o,
  input wire logic        fault_o,
  input wire fdp_cause_e  fault_cause_o,
  input wire logic        enhanced_power_factor_o,
  input wire logic        pullup_en_o,
  input wire logic [11:0] second_overcurrent_level_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  logic [15:0] ocp_cnt_q;
  logic [31:0] flt_cnt_q;
  // ****************
  // helper counters
  // ****************
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ocp_cnt_q <= '0;
    else if (gate_drive_o && cs_mv_i > second_overcurrent_level_o)
      ocp_cnt_q <= ocp_cnt_q + 16'h0001;
    else
      ocp_cnt_q <= '0;
  end
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      flt_cnt_q <= '0;
    else
      flt_cnt_q <= fault_o ? flt_cnt_q + 32'h1 : '0;
  end
  function automatic logic [11:0] ocp2_of(input logic [7:0] lvl);
    if (lvl <= 8'h36)
      return 12'h320;
    if (lvl <= 8'h48)
      return 12'h4b0;
    return 12'h640;
  endfunction
  // ****************
  // properties
  // ****************
  sequence s_over_blank;
    ocp_cnt_q == 16'(OCP_BLANK_CYC);
  endsequence
  sequence s_ocp_fault;
    ##[0:3] (fault_o && fault_cause_o == FC_OCP);
  endsequence
  property p_ocp_trip;
    s_over_blank |-> s_ocp_fault;
  endproperty
  a_ocp_trip: assert property (p_ocp_trip)
    else $error("overcurrent not flagged after blanking");
  property p_fault_gate;
    fault_o |-> !gate_drive_o;
  endproperty
  a_fault_gate: assert property (p_fault_gate)
    else $error("gate switching during fault");
  property p_fault_cause;
    $rose(fault_o) |-> fault_cause_o != FC_NONE;
  endproperty
  a_fault_cause: assert property (p_fault_cause)
    else $error("fault without cause");
  property p_restart_len;
    fault_o |-> flt_cnt_q <= RESTART_CYC + 2;
  endproperty
  a_restart_len: assert property (p_restart_len)
    else $error("auto-restart wait too long");
  property p_sleep_dark;
    sleep_o |-> !gate_drive_o && !light_on_o;
  endproperty
  a_sleep_dark: assert property (p_sleep_dark)
    else $error("activity while asleep");
  property p_pfc_off;
    !$past(input_cap_comp_gain_i != 8'h00) |-> !enhanced_power_factor_o;
  endproperty
  a_pfc_off: assert property (p_pfc_off)
    else $error("power factor feature on with zero gain");
  property p_ocp2_sel;
    $past(rst_b_i) |-> second_overcurrent_level_o == ocp2_of($past(first_overcurrent_level_i));
  endproperty
  a_ocp2_sel: assert property (p_ocp2_sel)
    else $error("wrong level two");
  property p_pullup;
    $past(rst_b_i) |->
      pullup_en_o == ($past(pullup_code_i) >= 8'h09 && $past(pullup_code_i) <= 8'h78);
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up enable wrong");
endmodule // fdp_top_sva

bind fdp_top fdp_top_sva #(
  .RESTART_CYC   (RESTART_CYC),
  .OCP_BLANK_CYC (OCP_BLANK_CYC)
) i_fdp_top_sva (
  .clk_i (clk_i), .rst_b_i (rst_b_i), .cs_mv_i (cs_mv_i),
  .first_overcurrent_level_i (first_overcurrent_level_i), .pullup_code_i (pullup_code_i),
  .input_cap_comp_gain_i (input_cap_comp_gain_i), .gate_drive_o (gate_drive_o),
  .sleep_o (sleep_o), .light_on_o (light_on_o), .fault_o (fault_o),
  .fault_cause_o (fault_cause_o), .pullup_en_o (pullup_en_o),
  .enhanced_power_factor_o (enhanced_power_factor_o),
  .second_overcurrent_level_o (second_overcurrent_level_o)
);

// file: verif/fdp_top_tb_top.sv
/*
  Self-checking bench of the flyback dimming and protection block.
  Assumes the package, the bound checker and the dimming source model.
*/
module fdp_top_tb_top import fdp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RST_CYC = 200;
  typedef struct packed {
    logic        inv;
    logic        quad;
    logic [15:0] high;
    logic [7:0]  duty;
    logic [15:0] sp;
  } fdp_row_s;
  localparam fdp_row_s ROWS [5] = '{
    '{1'b0, 1'b0, 16'h00f0, 8'hf0, 16'h1000}, '{1'b0, 1'b1, 16'h00fa, 8'hfa, 16'h1000},
    '{1'b1, 1'b0, 16'h00ec, 8'h14, 16'h0100}, '{1'b1, 1'b1, 16'h00f6, 8'h0a, 16'h0100},
    '{1'b1, 1'b0, 16'h00f4, 8'h0a, 16'h0100}};
  localparam logic [7:0]  LV [6]   = '{8'h28, 8'h36, 8'h37, 8'h48, 8'h49, 8'h6c};
  localparam logic [11:0] OCP2 [6] = '{12'h320, 12'h320, 12'h4b0, 12'h4b0, 12'h640, 12'h640};
  localparam logic [7:0]  PU [6]   = '{8'h08, 8'h09, 8'h78, 8'h79, 8'h00, 8'hff};
  localparam logic [5:0]  PUE      = 6'b000110;
  logic         clk_i, rst_b_i, dim_pwm_i, plim_en_i, qr1_mode_i, line_sync_i, seen;
  logic         gate_drive_o, sleep_o, light_on_o, fault_o, enhanced_power_factor_o, pullup_en_o;
  logic         valley_i = 1'b0;
  logic         gate_q   = 1'b0;
  fdp_dim_cfg_s dim_cfg_i;
  fdp_est_s     est_i;
  fdp_cause_e   fault_cause_o;
  logic [15:0]  iout_min_i, iout_full_i, ton_base_i, vout_dim_min_i, vout_start_i, high;
  logic [15:0]  iout_set_o, ton_o;
  logic [31:0]  pout_set_i;
  logic [7:0]   pullup_code_i, input_cap_comp_gain_i, first_overcurrent_level_i, duty_o;
  logic [23:0]  line_hsp_cyc_i, undervoltage_blanking_i;
  logic [11:0]  cs_mv_i, second_overcurrent_level_o;
  logic [5:0]   vcnt = '0;
  int           mismatches = 0, checks_done = 0, rises = 0, r0;

  fdp_top #(.RESTART_CYC(RST_CYC), .START_MAX_CYC(100), .DIM_SW_CYC(20), .HSP_CYC(512)) i_fdp_top (
    .clk_i (clk_i), .rst_b_i (rst_b_i), .dim_pwm_i (dim_pwm_i), .dim_cfg_i (dim_cfg_i),
    .iout_min_i (iout_min_i), .iout_full_i (iout_full_i), .plim_en_i (plim_en_i),
    .pout_set_i (pout_set_i), .pullup_code_i (pullup_code_i), .est_i (est_i),
    .qr1_mode_i (qr1_mode_i), .input_cap_comp_gain_i (input_cap_comp_gain_i),
    .ton_base_i (ton_base_i), .valley_i (valley_i), .line_sync_i (line_sync_i),
    .line_hsp_cyc_i (line_hsp_cyc_i), .cs_mv_i (cs_mv_i),
    .first_overcurrent_level_i (first_overcurrent_level_i), .vout_dim_min_i (vout_dim_min_i),
    .vout_start_i (vout_start_i), .undervoltage_blanking_i (undervoltage_blanking_i),
    .gate_drive_o (gate_drive_o), .sleep_o (sleep_o), .light_on_o (light_on_o),
    .fault_o (fault_o), .fault_cause_o (fault_cause_o), .iout_set_o (iout_set_o),
    .duty_o (duty_o), .ton_o (ton_o), .enhanced_power_factor_o (enhanced_power_factor_o),
    .pullup_en_o (pullup_en_o), .second_overcurrent_level_o (second_overcurrent_level_o));
  fdp_pwm_src i_fdp_pwm_src (.clk_i (clk_i), .period_i (16'h0100), .high_i (high),
    .pwm_o (dim_pwm_i));

  // ****************
  // clock, valley pulses, gate edge counter
  // ****************
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(negedge clk_i)
  begin
    vcnt     <= vcnt + 6'h01;
    valley_i <= (vcnt == 6'h3f);
  end
  always @(negedge clk_i)
  begin
    if (gate_drive_o && !gate_q)
      rises <= rises + 1;
    gate_q <= gate_drive_o;
  end
  initial
  begin
    #600000;
    mismatches++;
    end_of_test();
  end

  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
    checks_done++;
    if (seen_v !== exp_v)
    begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
    end
  endtask
  task automatic end_of_test();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // waits on fault (0), sleep (1) or light (2)
  task automatic wait_on(input int sel, input logic lvl, input int lim);
    int n;
    n = 0;
    while ((sel == 0 ? fault_o : sel == 1 ? sleep_o : light_on_o) !== lvl && n < lim)
    begin
      @(negedge clk_i);
      n++;
    end
    if (n >= lim)
    begin
      mismatches++;
      end_of_test();
    end
  endtask
  task automatic do_reset();
    rst_b_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk(second_overcurrent_level_o, 12'h320);
    chk(fault_o, 1'b0);
    rst_b_i = 1'b1;
  endtask

  // ****************
  // main sequence
  // ****************
  initial
  begin
    rst_b_i = 1'b0;
    dim_cfg_i = '{1'b0, 1'b0, 1'b0, 8'h04, 8'h1e, 8'hc8, 8'h0f, 8'h19};
    iout_min_i = 16'h0100;
    iout_full_i = 16'h1000;
    plim_en_i = 1'b0;
    pout_set_i = 32'hffff_ffff;
    pullup_code_i = 8'h00;
    est_i = '{16'h1000, 16'h2000, 16'h0800};
    qr1_mode_i = 1'b1;
    input_cap_comp_gain_i = 8'h00;
    ton_base_i = 16'h0008;
    line_sync_i = 1'b0;
    line_hsp_cyc_i = 24'h000200;
    cs_mv_i = 12'h000;
    first_overcurrent_level_i = 8'h28;
    vout_dim_min_i = 16'h2000;
    vout_start_i = 16'h1000;
    undervoltage_blanking_i = 24'h000100;
    high = 16'h00f0;
    do_reset();
    for (int r = 0; r < 5; r++)
    begin
      dim_cfg_i.inv = ROWS[r].inv;
      dim_cfg_i.quad = ROWS[r].quad;
      high = ROWS[r].high;
      repeat (1100) @(negedge clk_i);
      chk(duty_o, ROWS[r].duty);
      chk(iout_set_o, ROWS[r].sp);
      chk(light_on_o, 1'b1);
    end
    dim_cfg_i.inv = 1'b0;
    high = 16'h00f0;
    repeat (1100) @(negedge clk_i);
    plim_en_i = 1'b1;
    pout_set_i = 32'h0000_0001;
    repeat (1000) @(negedge clk_i);
    chk(iout_set_o inside {[16'h0e0b:16'h0e0e]}, 1'b1);
    pout_set_i = 32'hffff_ffff;
    repeat (600) @(negedge clk_i);
    chk(iout_set_o, 16'h1000);
    plim_en_i = 1'b0;
    chk(enhanced_power_factor_o, 1'b0);
    chk(ton_o, ton_base_i);
    input_cap_comp_gain_i = 8'h20;
    line_sync_i = 1'b1;
    line_hsp_cyc_i = 24'h000300;
    seen = 1'b0;
    repeat (1000)
    begin
      @(negedge clk_i);
      seen |= (ton_o !== ton_base_i);
    end
    chk(enhanced_power_factor_o, 1'b1);
    chk(seen, 1'b1);
    qr1_mode_i = 1'b0;
    repeat (600) @(negedge clk_i);
    chk(ton_o, ton_base_i);
    qr1_mode_i = 1'b1;
    input_cap_comp_gain_i = 8'h00;
    line_sync_i = 1'b0;
    ton_base_i = 16'h0040;
    repeat (900) @(negedge clk_i);
    cs_mv_i = 12'h320;
    repeat (300) @(negedge clk_i);
    chk(fault_o, 1'b0);
    cs_mv_i = 12'h321;
    wait_on(0, 1'b1, 200);
    chk(fault_cause_o, FC_OCP);
    chk(gate_drive_o, 1'b0);
    cs_mv_i = 12'h000;
    repeat (RST_CYC - 5) @(negedge clk_i);
    chk(fault_o, 1'b1);
    wait_on(0, 1'b0, 20);
    wait_on(2, 1'b1, 20);
    ton_base_i = 16'h0008;
    for (int i = 0; i < 6; i++)
    begin
      first_overcurrent_level_i = LV[i];
      pullup_code_i = PU[i];
      repeat (3) @(negedge clk_i);
      chk(second_overcurrent_level_o, OCP2[i]);
      chk(pullup_en_o, PUE[i]);
    end
    est_i.vout = 16'h1000;
    repeat (600) @(negedge clk_i);
    chk(fault_o, 1'b0);
    est_i.vout = 16'h0fff;
    wait_on(0, 1'b1, 400);
    chk(fault_cause_o, FC_UV);
    wait_on(0, 1'b0, RST_CYC + 20);
    repeat (90) @(negedge clk_i);
    chk(fault_o, 1'b0);
    wait_on(0, 1'b1, 30);
    chk(fault_cause_o, FC_START_UV);
    est_i.vout = 16'h2000;
    wait_on(0, 1'b0, RST_CYC + 20);
    wait_on(2, 1'b1, 20);
    dim_cfg_i.with_off = 1'b1;
    high = 16'h0028;
    do_reset();
    seen = 1'b0;
    repeat (1500)
    begin
      @(negedge clk_i);
      seen |= sleep_o;
    end
    chk(seen, 1'b0);
    chk(light_on_o, 1'b1);
    high = 16'h000a;
    wait_on(1, 1'b1, 2000);
    chk(light_on_o, 1'b0);
    est_i.vout = 16'h0800;
    repeat (RST_CYC - 5) @(negedge clk_i);
    chk(sleep_o, 1'b1);
    wait_on(1, 1'b0, 20);
    r0 = rises;
    repeat (100) @(negedge clk_i);
    chk((rises - r0) inside {[4:6]}, 1'b1);
    est_i.vout = 16'h2000;
    wait_on(1, 1'b1, 2000);
    chk(light_on_o, 1'b0);
    high = 16'h0028;
    wait_on(2, 1'b1, 4000);
    chk(sleep_o, 1'b0);
    end_of_test();
  end
endmodule // fdp_top_tb_top
